// ---- logic/ramp_trip_pkg.sv ----
package ramp_trip_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] RANGING_OFS = 8'hB9;
  localparam logic [7:0] STEP_HOT_OFS = 8'hBA;
  localparam logic [7:0] STEP_COLD_OFS = 8'hBB;
  localparam logic [7:0] HIGH_ADJ_OFS = 8'hBC;
  localparam logic [7:0] LOW_ADJ_OFS = 8'hBD;
  localparam logic [7:0] LOS_HIGH_OFS = 8'hBE;
  localparam logic [7:0] LOS_LOW_OFS = 8'hBF;
  localparam logic [7:0] BOUNDARY_OFS = 8'hC5;
  localparam logic [7:0] STATUS_OFS = 8'hD0;
  localparam logic [7:0] CEILING_OFS = 8'hEE;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] READ_NONE = 8'h00;

  // ==========================================================
  // Fields
  localparam int RANGE_LSB = 0;
  localparam int RANGE_W = 3;
  localparam int ST_TXHI = 0;
  localparam int ST_TXLO = 1;
  localparam int ST_LOSLO = 2;
  localparam int ST_LOSHI = 3;
  localparam int ST_SEARCH = 4;
  localparam int ST_DONE = 5;
  localparam int ST_BMAX = 6;

  localparam logic [7:0] CODE_MAX = 8'hFF;
  localparam logic [7:0] CODE_MIN = 8'h00;

  // Full-scale fraction of each ranging code, times 256.
  localparam logic [8:0] RANGE_MULT [8] = '{
    9'h100, 9'h0CD, 9'h0AB, 9'h080,
    9'h066, 9'h055, 9'h049, 9'h040
  };

  // ==========================================================
  // Timing
  localparam int CLK_NS = 20;
  localparam int EVAL_NS = 1000;
  localparam int EVAL_CYCLES = (EVAL_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [1:0] {
    ST_RAMP,
    ST_BSEARCH,
    ST_FINISHED
  } startup_state_e;

endpackage

// ---- logic/laser_bias_startup.sv ----
// Summary of operation
// - Temperature index above boundary selects the hot initial step.
// - Temperature index below boundary selects the cold initial step.
// - Ramp restarts at power-on and after every transmit-disable pulse.
// - Ramp adds twice the step plus one to bias until feedback crosses threshold.
// - Feedback crossing ends the ramp and starts the binary search.
// - A sum above the bias ceiling is dropped and search begins.
// - Bias-limit alarm is only detected after the search finishes.
// - High threshold is reference plus high adjust, saturating at FFh.
// - High power alarm while feedback exceeds the high threshold.
// - Low threshold is reference minus low adjust, clamped at 00h.
// - Low power alarm while feedback is below the low threshold.
// - Signal strength below low threshold sets the low loss flag.
// - Loss holds until above high threshold; then low clears, high sets.
// - Power-on clears both loss flags and watches the low threshold.
// - Reads need top level, or user level with either grant.
// - Writes need top level, or user level with read-write grant.
// - Three-bit ranging scales the comparison full scale, 000b full.
//
// The strobed register port was decided locally.
module laser_bias_startup #(
  parameter int BIAS_W = 10,
  parameter int EVAL_CNT = ramp_trip_pkg::EVAL_CYCLES
) (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic top_password_level_in,
  input wire logic user_password_level_in,
  input wire logic table_readwrite_grant_in,
  input wire logic table_read_grant_in,
  input wire logic [7:0] temperature_index_in,
  input wire logic [7:0] power_loop_reference_in,
  input wire logic [7:0] power_feedback_in,
  input wire logic [7:0] rssi_in,
  input wire logic tx_disable_in,
  output logic [7:0] rd_data_out,
  output logic [BIAS_W-1:0] bias_out,
  output logic startup_done_out,
  output logic bias_max_alarm_out,
  output logic tx_power_high_alarm_out,
  output logic tx_power_low_alarm_out,
  output logic signal_loss_low_flag_out,
  output logic signal_loss_high_flag_out
);
  import ramp_trip_pkg::*;

  // ==========================================================
  // Register file
  logic [7:0] power_loop_ranging;
  logic [7:0] init_step_hot;
  logic [7:0] init_step_cold;
  logic [7:0] tx_power_high_adjust;
  logic [7:0] tx_power_low_adjust;
  logic [7:0] signal_loss_high_threshold;
  logic [7:0] signal_loss_low_threshold;
  logic [7:0] step_temp_boundary;
  logic [7:0] bias_ceiling;
  logic rd_ok;
  logic wr_ok;
  logic [7:0] status;

  assign rd_ok = top_password_level_in | (user_password_level_in
    & (table_readwrite_grant_in | table_read_grant_in));
  assign wr_ok = top_password_level_in
    | (user_password_level_in & table_readwrite_grant_in);

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      power_loop_ranging <= REG_RESET;
      init_step_hot <= REG_RESET;
      init_step_cold <= REG_RESET;
      tx_power_high_adjust <= REG_RESET;
      tx_power_low_adjust <= REG_RESET;
      signal_loss_high_threshold <= REG_RESET;
      signal_loss_low_threshold <= REG_RESET;
      step_temp_boundary <= REG_RESET;
      bias_ceiling <= REG_RESET;
    end else if (ce_in && wr_in && wr_ok) begin
      case (addr_in)
        RANGING_OFS: power_loop_ranging <= wr_data_in;
        STEP_HOT_OFS: init_step_hot <= wr_data_in;
        STEP_COLD_OFS: init_step_cold <= wr_data_in;
        HIGH_ADJ_OFS: tx_power_high_adjust <= wr_data_in;
        LOW_ADJ_OFS: tx_power_low_adjust <= wr_data_in;
        LOS_HIGH_OFS: signal_loss_high_threshold <= wr_data_in;
        LOS_LOW_OFS: signal_loss_low_threshold <= wr_data_in;
        BOUNDARY_OFS: step_temp_boundary <= wr_data_in;
        CEILING_OFS: bias_ceiling <= wr_data_in;
        default: ;
      endcase
    end
  end

  // A refused or unmapped read answers zero rather than stalling.
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rd_data_out <= READ_NONE;
    end else if (ce_in) begin
      rd_data_out <= READ_NONE;
      if (rd_in && rd_ok) begin
        case (addr_in)
          RANGING_OFS: rd_data_out <= power_loop_ranging;
          STEP_HOT_OFS: rd_data_out <= init_step_hot;
          STEP_COLD_OFS: rd_data_out <= init_step_cold;
          HIGH_ADJ_OFS: rd_data_out <= tx_power_high_adjust;
          LOW_ADJ_OFS: rd_data_out <= tx_power_low_adjust;
          LOS_HIGH_OFS: rd_data_out <= signal_loss_high_threshold;
          LOS_LOW_OFS: rd_data_out <= signal_loss_low_threshold;
          BOUNDARY_OFS: rd_data_out <= step_temp_boundary;
          CEILING_OFS: rd_data_out <= bias_ceiling;
          STATUS_OFS: rd_data_out <= status;
          default: rd_data_out <= READ_NONE;
        endcase
      end
    end
  end

  // ==========================================================
  // Pin synchronisers
  // The analog codes are sampled as whole words; the converter must
  // hold each code steady for several clocks so no torn word is seen.
  logic [7:0] fb_meta;
  logic [7:0] fb_q;
  logic [7:0] rssi_meta;
  logic [7:0] rssi_q;
  logic txd_meta;
  logic txd_q;
  logic txd_last;

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      fb_meta <= CODE_MIN;
      fb_q <= CODE_MIN;
      rssi_meta <= CODE_MIN;
      rssi_q <= CODE_MIN;
      txd_meta <= 1'b0;
      txd_q <= 1'b0;
      txd_last <= 1'b0;
    end else if (ce_in) begin
      fb_meta <= power_feedback_in;
      fb_q <= fb_meta;
      rssi_meta <= rssi_in;
      rssi_q <= rssi_meta;
      txd_meta <= tx_disable_in;
      txd_q <= txd_meta;
      txd_last <= txd_q;
    end
  end

  // ==========================================================
  // Threshold arithmetic
  function automatic logic [7:0] scale(input logic [7:0] code,
                                       input logic [2:0] rng);
    logic [16:0] prod;
    prod = 17'(code) * 17'(RANGE_MULT[rng]);
    return prod[15:8];
  endfunction

  logic [2:0] rng;
  logic [8:0] high_sum;
  logic [7:0] high_code;
  logic [7:0] low_code;
  logic [7:0] apc_thr;
  logic [7:0] high_thr;
  logic [7:0] low_thr;
  logic fb_over;

  assign rng = power_loop_ranging[RANGE_LSB +: RANGE_W];
  assign high_sum = {1'b0, power_loop_reference_in} + {1'b0, tx_power_high_adjust};
  assign high_code = high_sum[8] ? CODE_MAX : high_sum[7:0];
  assign low_code = (tx_power_low_adjust > power_loop_reference_in) ? CODE_MIN
    : power_loop_reference_in - tx_power_low_adjust;
  assign apc_thr = scale(power_loop_reference_in, rng);
  assign high_thr = scale(high_code, rng);
  assign low_thr = scale(low_code, rng);
  assign fb_over = fb_q > apc_thr;

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      tx_power_high_alarm_out <= 1'b0;
      tx_power_low_alarm_out <= 1'b0;
    end else if (ce_in) begin
      tx_power_high_alarm_out <= fb_q > high_thr;
      tx_power_low_alarm_out <= fb_q < low_thr;
    end
  end

  // ==========================================================
  // Loss-of-signal hysteresis
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      signal_loss_low_flag_out <= 1'b0;
      signal_loss_high_flag_out <= 1'b0;
    end else if (ce_in) begin
      if (!signal_loss_low_flag_out) begin
        if (rssi_q < signal_loss_low_threshold) begin
          signal_loss_low_flag_out <= 1'b1;
        end
      end else if (rssi_q > signal_loss_high_threshold) begin
        signal_loss_low_flag_out <= 1'b0;
        signal_loss_high_flag_out <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Start-up sequencer
  localparam int SUM_W = BIAS_W + 1;
  localparam int IDX_W = $clog2(BIAS_W);
  localparam int TICK_W = $clog2(EVAL_CNT + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(EVAL_CNT - 1);

  startup_state_e state;
  logic [TICK_W-1:0] tick_cnt;
  logic tick;
  logic restart;
  logic [7:0] step_sel;
  logic [SUM_W-1:0] step_full;
  logic [SUM_W-1:0] ceil_full;
  logic [SUM_W-1:0] ramp_sum;
  logic ramp_over;
  logic adding;
  logic [IDX_W-1:0] bit_idx;
  logic trial_set;
  logic [BIAS_W-1:0] kept;
  logic [BIAS_W-1:0] trial;
  logic [BIAS_W-1:0] top_bit;

  assign restart = txd_last && !txd_q;
  assign tick = tick_cnt == '0;
  assign step_sel = (temperature_index_in > step_temp_boundary)
    ? init_step_hot
    : init_step_cold;
  assign step_full = SUM_W'({step_sel, 1'b1});
  assign ceil_full = SUM_W'({bias_ceiling, {(BIAS_W - 8){1'b1}}});
  assign ramp_sum = {1'b0, bias_out} + step_full;
  assign ramp_over = ramp_sum > ceil_full;
  assign adding = ce_in && state == ST_RAMP && tick && !restart
    && !fb_over && !ramp_over;
  assign top_bit = {1'b1, {(BIAS_W - 1){1'b0}}};
  assign kept = (trial_set && fb_over)
    ? bias_out & ~(BIAS_W'(1) << bit_idx) : bias_out;
  assign trial = kept | (BIAS_W'(1) << (bit_idx - IDX_W'(1)));

  // Comparator settle timer paces every ramp and search bias change.
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      tick_cnt <= TICK_LAST;
    end else if (ce_in) begin
      if (restart || tick) begin
        tick_cnt <= TICK_LAST;
      end else begin
        tick_cnt <= tick_cnt - TICK_W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state <= ST_RAMP;
      bias_out <= '0;
      bit_idx <= '0;
      trial_set <= 1'b0;
    end else if (ce_in) begin
      if (restart) begin
        state <= ST_RAMP;
        bias_out <= '0;
        trial_set <= 1'b0;
      end else if (tick) begin
        case (state)
          ST_RAMP: begin
            if (fb_over || ramp_over) begin
              // Search restarts from the top so it can also move down.
              state <= ST_BSEARCH;
              bit_idx <= IDX_W'(BIAS_W - 1);
              trial_set <= {1'b0, top_bit} <= ceil_full;
              bias_out <= ({1'b0, top_bit} <= ceil_full) ? top_bit : '0;
            end else begin
              bias_out <= ramp_sum[BIAS_W-1:0];
            end
          end
          ST_BSEARCH: begin
            if (bit_idx == '0) begin
              state <= ST_FINISHED;
              bias_out <= kept;
              trial_set <= 1'b0;
            end else begin
              bit_idx <= bit_idx - IDX_W'(1);
              trial_set <= {1'b0, trial} <= ceil_full;
              bias_out <= ({1'b0, trial} <= ceil_full) ? trial : kept;
            end
          end
          ST_FINISHED: ;
          default: state <= ST_RAMP;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      startup_done_out <= 1'b0;
      bias_max_alarm_out <= 1'b0;
    end else if (ce_in) begin
      startup_done_out <= state == ST_FINISHED && !restart;
      bias_max_alarm_out <= state == ST_FINISHED && !restart
        && {1'b0, bias_out} > ceil_full;
    end
  end

  always_comb begin
    status = '0;
    status[ST_TXHI] = tx_power_high_alarm_out;
    status[ST_TXLO] = tx_power_low_alarm_out;
    status[ST_LOSLO] = signal_loss_low_flag_out;
    status[ST_LOSHI] = signal_loss_high_flag_out;
    status[ST_SEARCH] = state == ST_BSEARCH;
    status[ST_DONE] = startup_done_out;
    status[ST_BMAX] = bias_max_alarm_out;
  end

  // ==========================================================
  // Checks
  a_hot_step: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    adding && temperature_index_in > step_temp_boundary
    |=> bias_out == $past(bias_out) + BIAS_W'({$past(init_step_hot), 1'b1}))
    else $error("hot step not applied");

  a_cold_step: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    adding && temperature_index_in <= step_temp_boundary
    |=> bias_out == $past(bias_out) + BIAS_W'({$past(init_step_cold), 1'b1}))
    else $error("cold step not applied");

  a_ramp_restart: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    ce_in && restart |=> state == ST_RAMP && bias_out == '0)
    else $error("disable pulse did not restart ramp");

  a_ceiling_stop: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    ce_in && tick && !restart && state == ST_RAMP && ramp_over
    |=> state == ST_BSEARCH && {1'b0, bias_out} <= $past(ceil_full))
    else $error("ceiling sum loaded");

  a_alarm_gated: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    state != ST_FINISHED ##1 state != ST_FINISHED |-> !bias_max_alarm_out)
    else $error("bias alarm during start-up");

  a_high_alarm: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    ce_in |=> tx_power_high_alarm_out == ($past(fb_q) > $past(high_thr)))
    else $error("high power alarm wrong");

  a_high_sat: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    high_code >= power_loop_reference_in
    && high_code >= tx_power_high_adjust)
    else $error("high threshold wrapped");

  a_low_clamp: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    low_code <= power_loop_reference_in)
    else $error("low threshold wrapped");

  a_los_set: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    ce_in && !signal_loss_low_flag_out
    && rssi_q < signal_loss_low_threshold |=> signal_loss_low_flag_out)
    else $error("loss flag not set");

  a_los_release: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    ce_in && signal_loss_low_flag_out && rssi_q > signal_loss_high_threshold
    |=> !signal_loss_low_flag_out && signal_loss_high_flag_out)
    else $error("loss release wrong");

  a_write_gate: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    wr_in && !wr_ok |=> $stable(init_step_hot) && $stable(bias_ceiling))
    else $error("write passed the password gate");

  a_read_gate: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    ce_in && rd_in && !rd_ok |=> rd_data_out == READ_NONE)
    else $error("read passed the password gate");

  a_step_pace: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    adding |=> !adding [*2])
    else $error("ramp steps too close");

endmodule

// ---- tb/bias_path_model.sv ----
module bias_path_model (
  input wire logic ref_clk_in,
  input wire logic [9:0] bias_in,
  input wire logic slow_in,
  input wire logic fixed_en_in,
  input wire logic [7:0] fixed_code_in,
  output logic [7:0] feedback_out
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // Optical path
  // Feedback follows the bias linearly; the slow mode adds two cycles of optical lag.
  logic [7:0] lag1;
  logic [7:0] lag2;

  always_ff @(posedge ref_clk_in) begin
    lag1 <= bias_in[9:2];
    lag2 <= lag1;
  end

  // A fixed code stands in for a photodiode held at one level.
  always_comb begin
    if (fixed_en_in) begin
      feedback_out = fixed_code_in;
    end else if (slow_in) begin
      feedback_out = lag2;
    end else begin
      feedback_out = bias_in[9:2];
    end
  end
endmodule

// ---- tb/test_laser_bias_startup.sv ----
module test_laser_bias_startup;
  import ramp_trip_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // Signals
  // A short evaluation period keeps the ramps brief but still covers the feedback lag.
  localparam int EVAL = 8;
  logic ref_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, temp = 8'h00, ref_code = 8'h00;
  logic [7:0] rssi = 8'h50, fixed_code = 8'h00, rdata, fb;
  logic [7:0] rdata_q;
  logic wr = 1'b0, rd = 1'b0, top = 1'b1, user = 1'b0, rwg = 1'b0, rdg = 1'b0;
  logic txd = 1'b0, slow = 1'b0, fixed_en = 1'b0, ce = 1'b1;
  logic [9:0] bias;
  logic done, bmax, thi, tlo, llo, lhi;
  int fails = 0;
  int checked = 0;

  always #10 ref_clk_in = ~ref_clk_in;

  laser_bias_startup #(.BIAS_W(10), .EVAL_CNT(EVAL)) dut (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .ce_in(ce),
    .addr_in(addr), .wr_data_in(wdata), .wr_in(wr), .rd_in(rd),
    .top_password_level_in(top), .user_password_level_in(user),
    .table_readwrite_grant_in(rwg), .table_read_grant_in(rdg),
    .temperature_index_in(temp), .power_loop_reference_in(ref_code),
    .power_feedback_in(fb), .rssi_in(rssi), .tx_disable_in(txd),
    .rd_data_out(rdata_q), .bias_out(bias), .startup_done_out(done),
    .bias_max_alarm_out(bmax), .tx_power_high_alarm_out(thi),
    .tx_power_low_alarm_out(tlo), .signal_loss_low_flag_out(llo),
    .signal_loss_high_flag_out(lhi));

  bias_path_model partner (.ref_clk_in(ref_clk_in), .bias_in(bias), .slow_in(slow),
    .fixed_en_in(fixed_en), .fixed_code_in(fixed_code), .feedback_out(fb));

  // ==========================================================
  // Helpers
  task automatic summarize;
    if (fails == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // A wait that runs out of its bound is a mismatch and ends the run at once.
  task automatic give_up(input logic hit);
    if (hit) begin
      fails++;
      summarize;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge ref_clk_in);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(posedge ref_clk_in);
    rd <= 1'b1; addr <= a;
    @(posedge ref_clk_in);
    rd <= 1'b0;
    #1 rdata = rdata_q;
  endtask

  task automatic set_pw(input logic t, input logic u, input logic w, input logic r);
    @(posedge ref_clk_in);
    top <= t; user <= u; rwg <= w; rdg <= r;
  endtask

  // The pulse must outlast the pin synchroniser before the ramp is watched.
  task automatic restart;
    @(posedge ref_clk_in);
    txd <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    txd <= 1'b0;
    tick(4);
  endtask

  task automatic wait_done;
    int n;
    n = 0;
    while (done !== 1'b1 && n < 3000) begin
      tick(1);
      n++;
    end
    give_up(n >= 3000);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset_values;
    for (int i = 0; i < 6; i++) begin
      rd_reg(STEP_HOT_OFS + 8'(i));
      check(16'(rdata), 16'(REG_RESET));
    end
    check(16'({llo, lhi}), 16'h0000);
  endtask

  task automatic t_access;
    wr_reg(LOW_ADJ_OFS, 8'h5A);
    rd_reg(LOW_ADJ_OFS);
    check(16'(rdata), 16'h005A);
    set_pw(1'b0, 1'b1, 1'b0, 1'b0);
    wr_reg(LOW_ADJ_OFS, 8'hA5);
    rd_reg(LOW_ADJ_OFS);
    check(16'(rdata), 16'(READ_NONE));
    set_pw(1'b0, 1'b1, 1'b0, 1'b1);
    wr_reg(LOW_ADJ_OFS, 8'h33);
    rd_reg(LOW_ADJ_OFS);
    check(16'(rdata), 16'h005A);
    set_pw(1'b0, 1'b1, 1'b1, 1'b0);
    wr_reg(LOW_ADJ_OFS, 8'h33);
    rd_reg(LOW_ADJ_OFS);
    check(16'(rdata), 16'h0033);
    set_pw(1'b0, 1'b0, 1'b1, 1'b1);
    rd_reg(LOW_ADJ_OFS);
    check(16'(rdata), 16'(READ_NONE));
    set_pw(1'b1, 1'b0, 1'b0, 1'b0);
    rd_reg(8'h10);
    check(16'(rdata), 16'(READ_NONE));
  endtask

  task automatic tx_case(input logic [7:0] r, input logic [7:0] h, input logic [7:0] l,
                         input logic [7:0] f, input logic [2:0] g, input logic hi,
                         input logic lo);
    wr_reg(RANGING_OFS, {5'h00, g});
    wr_reg(HIGH_ADJ_OFS, h);
    wr_reg(LOW_ADJ_OFS, l);
    @(posedge ref_clk_in);
    ref_code <= r; fixed_code <= f;
    tick(6);
    check(16'(thi), 16'(hi));
    check(16'(tlo), 16'(lo));
  endtask

  task automatic t_power;
    @(posedge ref_clk_in);
    fixed_en <= 1'b1;
    tx_case(8'hF0, 8'h20, 8'h00, 8'hFF, 3'h0, 1'b0, 1'b0);
    tx_case(8'hF0, 8'h05, 8'h00, 8'hF6, 3'h0, 1'b1, 1'b0);
    tx_case(8'hF0, 8'h05, 8'h00, 8'hF5, 3'h0, 1'b0, 1'b0);
    tx_case(8'h10, 8'h00, 8'h20, 8'h00, 3'h0, 1'b0, 1'b0);
    tx_case(8'h10, 8'h00, 8'h05, 8'h0A, 3'h0, 1'b0, 1'b1);
    tx_case(8'h10, 8'h00, 8'h05, 8'h0B, 3'h0, 1'b0, 1'b0);
    // Adjustments are ranged with the same code as the reference.
    tx_case(8'hF0, 8'h05, 8'h00, 8'h7B, 3'h3, 1'b1, 1'b0);
    tx_case(8'hF0, 8'h05, 8'h00, 8'h7A, 3'h3, 1'b0, 1'b0);
    tx_case(8'hF0, 8'h00, 8'h10, 8'h6F, 3'h3, 1'b0, 1'b1);
    wr_reg(RANGING_OFS, 8'h00);
    @(posedge ref_clk_in);
    fixed_en <= 1'b0;
  endtask

  task automatic los_case(input logic [7:0] s, input logic lo, input logic hi);
    @(posedge ref_clk_in);
    rssi <= s;
    tick(5);
    check(16'({llo, lhi}), 16'({lo, hi}));
  endtask

  task automatic t_los;
    wr_reg(LOS_LOW_OFS, 8'h40);
    wr_reg(LOS_HIGH_OFS, 8'h80);
    los_case(8'h50, 1'b0, 1'b0);
    los_case(8'h3F, 1'b1, 1'b0);
    los_case(8'h80, 1'b1, 1'b0);
    los_case(8'h81, 1'b0, 1'b1);
  endtask

  task automatic ramp_case(input logic [7:0] t, input logic [9:0] step, input logic s);
    int n;
    @(posedge ref_clk_in);
    temp <= t; slow <= s;
    restart;
    n = 0;
    while (bias !== step && n < 4 * EVAL) begin
      tick(1);
      n++;
    end
    give_up(n >= 4 * EVAL);
    check(16'(bias), 16'(step));
    n = 0;
    while (bias === step && n < 100) begin
      tick(1);
      n++;
    end
    give_up(n >= 100);
    check(16'(bias), 16'(step * 2));
    check(16'(n), 16'(EVAL));
    wait_done;
    check(16'(bias), 16'h0103);
  endtask

  task automatic t_steps;
    wr_reg(BOUNDARY_OFS, 8'h40);
    wr_reg(STEP_HOT_OFS, 8'h07);
    wr_reg(STEP_COLD_OFS, 8'h02);
    wr_reg(CEILING_OFS, 8'hFF);
    @(posedge ref_clk_in);
    ref_code <= 8'h40;
    ramp_case(8'h41, 10'h00F, 1'b0);
    ramp_case(8'h3F, 10'h005, 1'b1);
    ramp_case(8'h40, 10'h005, 1'b0);
  endtask

  task automatic t_ceiling;
    int n;
    wr_reg(CEILING_OFS, 8'h20);
    @(posedge ref_clk_in);
    temp <= 8'h41;
    restart;
    n = 0;
    while (done !== 1'b1 && n < 3000) begin
      tick(1);
      n++;
      if (bias > 10'h083) check(16'(bias), 16'h0083);
      check(16'(bmax), 16'h0000);
    end
    give_up(n >= 3000);
    check(16'(bias), 16'h0083);
    wr_reg(CEILING_OFS, 8'h00);
    tick(3);
    check(16'(bmax), 16'h0001);
    wr_reg(CEILING_OFS, 8'hFF);
    rd_reg(STATUS_OFS);
    check(16'(rdata), 16'h002A);
  endtask

  // Clock enable low must hold the ramp between steps and drop bus writes.
  task automatic t_freeze;
    restart;
    tick(EVAL);
    @(posedge ref_clk_in);
    ce <= 1'b0;
    wr_reg(STEP_HOT_OFS, 8'h01);
    tick(3 * EVAL);
    check(16'(bias), 16'h000F);
    @(posedge ref_clk_in);
    ce <= 1'b1;
    rd_reg(STEP_HOT_OFS);
    check(16'(rdata), 16'h0007);
    wait_done;
    check(16'(bias), 16'h0103);
  endtask

  // A second reset must clear the sticky high loss flag and start a fresh ramp.
  task automatic t_reset_again;
    @(posedge ref_clk_in);
    reset_in <= 1'b1;
    tick(2);
    check(16'({llo, lhi, bias}), 16'h0000);
    @(posedge ref_clk_in);
    reset_in <= 1'b0;
    tick(EVAL);
    check(16'(bias), 16'h0001);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    @(posedge ref_clk_in);
    t_reset_values;
    t_access;
    t_power;
    t_los;
    t_steps;
    t_ceiling;
    t_freeze;
    t_reset_again;
    summarize;
  end
endmodule
